/* hdl/ddp_pkg.sv */
// ddp_pkg: constants shared by the dual data pointer block.
// assumes an 8-bit special-function register bus with 8-bit addresses.
package ddp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] DDP_AUX_ADDR = 8'hA2;
    // the core reaches the active pointer as two byte registers
    localparam logic [7:0] DDP_PTR_LO_ADDR = 8'h82;
    localparam logic [7:0] DDP_PTR_HI_ADDR = 8'h83;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DDP_SEL_BIT = 0;
    localparam int DDP_ZERO_BIT = 2;
    localparam int DDP_FLAG_BIT = 3;
    localparam int DDP_BOOT_BIT = 5;
    localparam logic [7:0] DDP_RSVD_MASK = 8'hD2;
    // ------------------------------------------------------------
    // values after reset and boot window
    // ------------------------------------------------------------
    localparam logic [15:0] DDP_PTR_RESET = 16'h0000;
    localparam logic DDP_SEL_RESET = 1'b0;
    localparam logic DDP_FLAG_RESET = 1'b0;
    localparam logic [15:0] DDP_BOOT_BASE = 16'hF800;
    localparam logic [15:0] DDP_BOOT_TOP = 16'hFFFF;
    localparam int DDP_PTR_COUNT = 2;
endpackage : ddp_pkg

/* hdl/ddp_ptr_if.sv */
// ddp_ptr_if: write and read path between the top and each pointer.
// assumes one clock domain shared with the pointer modules.
`timescale 1ns/10ps
`default_nettype none
interface ddp_ptr_if;
    logic wr_lo;
    logic wr_hi;
    logic inc;
    logic ld;
    logic [7:0] wdata;
    logic [15:0] ldata;
    logic [15:0] value;
    modport ctrl (output wr_lo, wr_hi, inc, ld, wdata, ldata, input value);
    modport ptr (input wr_lo, wr_hi, inc, ld, wdata, ldata, output value);
endinterface : ddp_ptr_if
`default_nettype wire

/* hdl/ddp_pointer.sv */
// ddp_pointer: one 16-bit data pointer with byte writes, load and increment.
// assumes strobes are only raised for the selected pointer.
`timescale 1ns/10ps
`default_nettype none
module ddp_pointer import ddp_pkg::*; #(
    parameter int WIDTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    ddp_ptr_if.ptr bus
);
    typedef struct packed {
        logic [WIDTH-1:0] value;
    } ddp_ptr_s;
    ddp_ptr_s st;
    ddp_ptr_s next_st;

    always_comb begin
        next_st = st;
        if (bus.ld) begin
            next_st.value = bus.ldata;
        end else if (bus.inc) begin
            next_st.value = st.value + 16'h0001;
        end else begin
            if (bus.wr_lo) begin
                next_st.value[7:0] = bus.wdata;
            end
            if (bus.wr_hi) begin
                next_st.value[15:8] = bus.wdata;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st.value <= DDP_PTR_RESET;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign bus.value = st.value;
endmodule : ddp_pointer
`default_nettype wire

/* hdl/ddp_top.sv */
// ddp_top: dual data pointer with the auxiliary pointer and boot control register.
// assumes the core raises one-cycle strobes on the register bus and supplies
// read-modify-write for increment as i_sfr_inc on the auxiliary address.
//
// How it works
// - two separate 16-bit pointers, either can address external data memory
// - control bit 0 picks pointer: zero first, one second
// - control bit 5 maps boot memory into code space F800h..FFFFh
// - control bit 2 reads zero, ignores writes; increment leaves flag unchanged
// - reserved bits 7,6,4,1 read zero; software writes zero there
// - incrementing the control register toggles the select bit
`timescale 1ns/10ps
`default_nettype none
module ddp_top import ddp_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_inc,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_ptr_inc,
    input wire logic i_ptr_ld,
    input wire logic [15:0] i_ptr_ldata,
    input wire logic i_bootloader_jump_fuse,
    input wire logic [15:0] i_code_addr,
    output logic [7:0] o_sfr_rdata,
    output logic [15:0] o_xdata_addr,
    output logic o_boot_map_enable,
    output logic o_boot_hit
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic pointer_select;
        logic user_flag_bit;
        logic boot_map_enable;
        logic fuse_pending;
        logic [7:0] rdata;
        logic [15:0] xaddr;
        logic boot_hit;
    } ddp_state_s;
    ddp_state_s st;
    ddp_state_s next_st;

    // fuse is a strap: sync before use, caught after reset release
    logic fuse_s1;
    logic fuse_s2;

    ddp_ptr_if pif [DDP_PTR_COUNT] ();
    logic [15:0] active_ptr;
    logic [7:0] aux_image;
    logic aux_wr;
    logic aux_inc;

    assign aux_wr = i_sfr_wr && (i_sfr_addr == DDP_AUX_ADDR);
    assign aux_inc = i_sfr_inc && (i_sfr_addr == DDP_AUX_ADDR);

    // ------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DDP_PTR_COUNT; g++) begin : g_ptr
            logic mine;
            assign mine = (st.pointer_select == 1'(g));
            assign pif[g].wr_lo = mine && i_sfr_wr && (i_sfr_addr == DDP_PTR_LO_ADDR);
            assign pif[g].wr_hi = mine && i_sfr_wr && (i_sfr_addr == DDP_PTR_HI_ADDR);
            assign pif[g].inc = mine && i_ptr_inc;
            assign pif[g].ld = mine && i_ptr_ld;
            assign pif[g].wdata = i_sfr_wdata;
            assign pif[g].ldata = i_ptr_ldata;
            ddp_pointer #(.WIDTH(16)) u_ptr (
                .i_core_clk(i_core_clk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .bus(pif[g])
            );
        end
    endgenerate

    assign active_ptr = st.pointer_select ? pif[1].value : pif[0].value;

    // reserved bits read as zero here; bit 2 is never stored
    always_comb begin
        aux_image = 8'h00;
        aux_image[DDP_SEL_BIT] = st.pointer_select;
        aux_image[DDP_FLAG_BIT] = st.user_flag_bit;
        aux_image[DDP_BOOT_BIT] = st.boot_map_enable;
        aux_image[DDP_ZERO_BIT] = 1'b0;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.fuse_pending = 1'b0;
        if (st.fuse_pending) begin
            next_st.boot_map_enable = fuse_s2;
        end
        if (aux_wr) begin
            next_st.pointer_select = i_sfr_wdata[DDP_SEL_BIT];
            next_st.user_flag_bit = i_sfr_wdata[DDP_FLAG_BIT];
            next_st.boot_map_enable = i_sfr_wdata[DDP_BOOT_BIT];
        end else if (aux_inc) begin
            // reserved bit 1, never stored and read as zero, absorbs the carry out of bit 0
            next_st.pointer_select = ~st.pointer_select;
        end
        case (i_sfr_addr)
            DDP_AUX_ADDR: next_st.rdata = aux_image;
            DDP_PTR_LO_ADDR: next_st.rdata = active_ptr[7:0];
            DDP_PTR_HI_ADDR: next_st.rdata = active_ptr[15:8];
            default: next_st.rdata = 8'h00;
        endcase
        next_st.xaddr = active_ptr;
        next_st.boot_hit = st.boot_map_enable
            && (i_code_addr >= DDP_BOOT_BASE) && (i_code_addr <= DDP_BOOT_TOP);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        // synchroniser ignores reset so the strap is settled at release
        if (i_ce) begin
            fuse_s1 <= i_bootloader_jump_fuse;
            fuse_s2 <= fuse_s1;
        end
        if (i_rst) begin
            st <= '0;
            st.pointer_select <= DDP_SEL_RESET;
            st.user_flag_bit <= DDP_FLAG_RESET;
            st.fuse_pending <= 1'b1;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_sfr_rdata = st.rdata;
    assign o_xdata_addr = st.xaddr;
    assign o_boot_map_enable = st.boot_map_enable;
    assign o_boot_hit = st.boot_hit;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_aux_inc;
        i_ce && aux_inc && !aux_wr;
    endsequence

    // a read of the control register with nothing else touching it
    sequence s_aux_read;
        i_ce && !i_rst && (i_sfr_addr == DDP_AUX_ADDR) && !aux_wr && !aux_inc;
    endsequence

    sequence s_ptr_ld;
        i_ce && !i_rst && i_ptr_ld && !i_sfr_wr && !i_sfr_inc;
    endsequence

    // quiet cycle: no strobe can move the value in flight
    sequence s_ptr_quiet;
        i_ce && !i_rst && !i_ptr_ld && !i_ptr_inc && !i_sfr_wr && !i_sfr_inc;
    endsequence

    chk_inc_toggles_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_aux_inc |=> st.pointer_select != $past(st.pointer_select))
        else $error("increment did not toggle select");
    chk_inc_keeps_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_aux_inc |=> st.user_flag_bit == $past(st.user_flag_bit))
        else $error("increment disturbed user flag");
    chk_bit2_reads_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && i_sfr_addr == DDP_AUX_ADDR) |=> !o_sfr_rdata[DDP_ZERO_BIT])
        else $error("bit 2 read as one");
    chk_write_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && aux_wr) |=> st.pointer_select == $past(i_sfr_wdata[DDP_SEL_BIT]))
        else $error("select not written");
    chk_xaddr_follows: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && st.pointer_select) |=> o_xdata_addr == $past(pif[1].value))
        else $error("address not from second pointer");
    chk_boot_window: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !st.boot_map_enable) |=> !o_boot_hit)
        else $error("boot hit while unmapped");
    chk_reset_clears: assert property (@(posedge i_core_clk)
        i_rst |=> (!st.pointer_select && !st.user_flag_bit))
        else $error("reset left select or flag set");
    chk_fuse_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!i_rst && st.fuse_pending && i_ce && !aux_wr) |=> o_boot_map_enable == $past(fuse_s2))
        else $error("boot enable not loaded from fuse");

    chk_inc_keeps_boot: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_aux_inc ##0 !st.fuse_pending) |=> st.boot_map_enable == $past(st.boot_map_enable))
        else $error("increment disturbed boot enable");
    chk_inc_read_back: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_aux_inc ##0 !i_rst ##1 s_aux_read)
            |=> o_sfr_rdata[DDP_SEL_BIT] != $past(st.pointer_select, 2))
        else $error("read after increment shows old select");
    chk_write_boot: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_rst && aux_wr) |=> o_boot_map_enable == $past(i_sfr_wdata[DDP_BOOT_BIT]))
        else $error("boot enable not written");

    // ------------------------------------------------------------
    // checks on pointers, reads and the boot window
    // ------------------------------------------------------------
    chk_xaddr_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_rst && !st.pointer_select) |=> o_xdata_addr == $past(pif[0].value))
        else $error("address not from first pointer");
    chk_ld_reaches_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_ptr_ld ##1 s_ptr_quiet) |=> o_xdata_addr == $past(i_ptr_ldata, 2))
        else $error("loaded value missing from address");
    chk_aux_read_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_rst && i_sfr_addr == DDP_AUX_ADDR)
            |=> o_sfr_rdata[DDP_SEL_BIT] == $past(st.pointer_select))
        else $error("select bit read wrong");
    chk_rsvd_reads_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_rst && i_sfr_addr == DDP_AUX_ADDR)
            |=> (o_sfr_rdata & DDP_RSVD_MASK) == 8'h00)
        else $error("reserved bit read as one");
    chk_hit_in_window: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_rst && st.boot_map_enable && i_code_addr >= DDP_BOOT_BASE) |=> o_boot_hit)
        else $error("boot window missed");
    chk_hit_below: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_rst && i_code_addr < DDP_BOOT_BASE) |=> !o_boot_hit)
        else $error("boot hit below window");

    // a low enable must hold the whole state register and the synchroniser output
    chk_ce_freeze: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!i_rst && !i_ce) |=> ($stable(st) && $stable(fuse_s2)))
        else $error("state moved while enable low");
endmodule : ddp_top
`default_nettype wire

/* bench/ddp_core_model.sv */
// ddp_core_model: core side of the register bus, one strobe per call.
// assumes its tasks are called from one bench process only.
`timescale 1ns/10ps
`default_nettype none
module ddp_core_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_sfr_rdata,
    output logic o_wr,
    output logic o_inc,
    output logic o_ld,
    output logic o_pinc,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic [15:0] o_ldata
);
    initial begin
        {o_wr, o_inc, o_ld, o_pinc} = 4'h0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_ldata = 16'h0000;
    end
    // kind bits: write, register increment, pointer load, pointer increment
    task automatic pulse(input logic [3:0] kind, input logic [7:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d[7:0];
        o_ldata <= d;
        {o_wr, o_inc, o_ld, o_pinc} <= kind;
        @(posedge i_core_clk);
        {o_wr, o_inc, o_ld, o_pinc} <= 4'h0;
        // stale data must not look valid once released
        o_wdata <= ~d[7:0];
        o_ldata <= ~d;
    endtask : pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        @(posedge i_core_clk);
        #1;
        d = i_sfr_rdata;
    endtask : rd
endmodule : ddp_core_model
`default_nettype wire

/* bench/dual_data_pointer_select_bench.sv */
// dual_data_pointer_select_bench: directed register and pointer tests.
// assumes the core model drives the bus; clock enable drops once to show the freeze.
`timescale 1ns/10ps
`default_nettype none
`define DDP_CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module dual_data_pointer_select_bench import ddp_pkg::*;;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic fuse = 1'b1;
    logic ce = 1'b1;
    logic [15:0] code_addr = 16'h0000;
    logic wr, inc, ld, pinc, boot_en, boot_hit;
    logic [7:0] addr, wdata, rdata;
    logic [15:0] ldata, xaddr;
    int num_errors = 0;
    int comparisons = 0;
    initial forever #2 core_clk = ~core_clk;
    ddp_core_model ddp_core_model_i (.i_core_clk(core_clk), .i_sfr_rdata(rdata), .o_wr(wr),
        .o_inc(inc), .o_ld(ld), .o_pinc(pinc), .o_addr(addr), .o_wdata(wdata), .o_ldata(ldata));
    ddp_top ddp_top_i (.i_core_clk(core_clk), .i_rst(rst), .i_ce(ce), .i_sfr_wr(wr),
        .i_sfr_inc(inc), .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_ptr_inc(pinc),
        .i_ptr_ld(ld), .i_ptr_ldata(ldata), .i_bootloader_jump_fuse(fuse),
        .i_code_addr(code_addr), .o_sfr_rdata(rdata), .o_xdata_addr(xaddr),
        .o_boot_map_enable(boot_en), .o_boot_hit(boot_hit));
    task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        ddp_core_model_i.rd(a, d);
        `DDP_CHECK(d, e)
    endtask : reg_is
    task automatic settle;
        @(posedge core_clk);
        #1;
    endtask : settle
    task automatic hit_is(input logic [15:0] a, input logic e);
        @(posedge core_clk);
        code_addr <= a;
        settle();
        `DDP_CHECK(boot_hit, e)
    endtask : hit_is
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        reg_is(DDP_AUX_ADDR, 8'h20);
        `DDP_CHECK(boot_en, 1'b1)
        $display("test reset done");
        // bit 2 written as one must still read zero; reserved places get zeros
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h002D);
        reg_is(DDP_AUX_ADDR, 8'h29);
        ddp_core_model_i.pulse(4'h4, DDP_AUX_ADDR, 16'h0000);
        reg_is(DDP_AUX_ADDR, 8'h28);
        ddp_core_model_i.pulse(4'h4, DDP_AUX_ADDR, 16'h0000);
        reg_is(DDP_AUX_ADDR, 8'h29);
        // an increment while the enable is low must be lost
        @(posedge core_clk);
        ce <= 1'b0;
        ddp_core_model_i.pulse(4'h4, DDP_AUX_ADDR, 16'h0000);
        ce <= 1'b1;
        reg_is(DDP_AUX_ADDR, 8'h29);
        $display("test control done");
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h0008);
        ddp_core_model_i.pulse(4'h2, 8'h00, 16'h1234);
        settle();
        `DDP_CHECK(xaddr, 16'h1234)
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h0009);
        ddp_core_model_i.pulse(4'h2, 8'h00, 16'hABCD);
        ddp_core_model_i.pulse(4'h1, 8'h00, 16'h0000);
        settle();
        `DDP_CHECK(xaddr, 16'hABCE)
        ddp_core_model_i.pulse(4'h4, DDP_AUX_ADDR, 16'h0000);
        settle();
        `DDP_CHECK(xaddr, 16'h1234)
        ddp_core_model_i.pulse(4'h8, DDP_PTR_LO_ADDR, 16'h0055);
        settle();
        `DDP_CHECK(xaddr, 16'h1255)
        reg_is(DDP_PTR_HI_ADDR, 8'h12);
        reg_is(8'h90, 8'h00);
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h0001);
        ddp_core_model_i.pulse(4'h8, DDP_PTR_HI_ADDR, 16'h0077);
        reg_is(DDP_PTR_HI_ADDR, 8'h77);
        reg_is(DDP_PTR_LO_ADDR, 8'hCE);
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h0000);
        reg_is(DDP_PTR_LO_ADDR, 8'h55);
        $display("test pointers done");
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h0020);
        hit_is(16'hF7FF, 1'b0);
        hit_is(16'hF800, 1'b1);
        hit_is(16'hFFFF, 1'b1);
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h0000);
        hit_is(16'hFFFF, 1'b0);
        `DDP_CHECK(boot_en, 1'b0)
        $display("test boot done");
        // select and flag set so the second reset has something to clear
        ddp_core_model_i.pulse(4'h8, DDP_AUX_ADDR, 16'h0009);
        @(posedge core_clk);
        rst <= 1'b1;
        fuse <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        reg_is(DDP_AUX_ADDR, 8'h00);
        `DDP_CHECK(boot_en, 1'b0)
        $display("test second reset done");
        close_out();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        close_out();
    end
endmodule : dual_data_pointer_select_bench
`default_nettype wire
